// ### core/ctcm_top.sv
// Purpose: CPU thermal cool-down manager
// Assumes: Register port with read data one cycle after the read strobe
// Notes: Sense input may come from a dedicated pin or an external multiplexer
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
module ctcm_top
#(
    parameter int SAMPLE_DIV = ctcm_pkg::SAMPLE_DIV,
    parameter int SAMPLES_PER_HOLDOFF = ctcm_pkg::SAMPLES_PER_HOLDOFF
)
(
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // Register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    // CPU status and sense inputs
    input wire logic [2:0] cpu_mode_i,
    input wire logic emergency_sense_input_i,
    // Clock control outputs
    output logic cooldown_active_o,
    output logic [1:0] cooldown_clock_divisor_o,
    output logic system_management_interrupt_o,
    output logic [7:0] stop_clock_cfg_c_o,
    output logic [1:0] stop_clock_cfg_o
);
    logic [7:0] reg_eql;
    logic [7:0] reg_otl;
    logic [7:0] reg_cfg;
    logic [7:0] reg_stp_c;
    logic [1:0] reg_stp;
    logic reg_evt_en;
    logic reg_pol;
    logic [7:0] next_eql;
    logic [7:0] next_otl;
    logic [7:0] next_cfg;
    logic [7:0] next_stp_c;
    logic [1:0] next_stp;
    logic next_evt_en;
    logic next_pol;
    logic locked;
    logic [7:0] rdata;
    logic [7:0] next_rdata;

    ctcm_pkg::ctcm_state_t state;
    ctcm_pkg::ctcm_state_t next_state;
    logic [ctcm_pkg::CNT_W-1:0] activity_counter;
    logic [ctcm_pkg::CNT_W-1:0] next_activity_counter;
    logic [15:0] div_cnt;
    logic [15:0] next_div_cnt;
    logic [3:0] sub_cnt;
    logic [3:0] next_sub_cnt;
    logic [31:0] sample_cnt;
    logic [31:0] next_sample_cnt;
    logic [2:0] period_cnt;
    logic [2:0] next_period_cnt;
    logic irq;
    logic next_irq;

    ctcm_step_if step_bus ();
    ctcm_step u_step
    (
        .s(step_bus)
    );

    logic [1:0] cpu_efficiency;
    logic [1:0] cooldown_holdoff;
    logic [1:0] cooldown_timeout;
    logic [7:0] equilibrium_level;
    logic [7:0] overtemp_limit;
    logic sense_active;
    logic base_tick;
    logic sample_tick;
    logic holdoff_end;
    logic [2:0] timeout_periods;
    logic wr_lockable;
    logic last_period;

    assign locked = reg_eql[ctcm_pkg::ENABLE_BIT];
    assign equilibrium_level = {1'b0, reg_eql[ctcm_pkg::EQL_MSB:0]};
    assign overtemp_limit = reg_otl;
    assign cpu_efficiency = reg_cfg[ctcm_pkg::EFF_LSB +: 2];
    assign cooldown_holdoff = reg_cfg[ctcm_pkg::HOLD_LSB +: 2];
    assign cooldown_timeout = reg_cfg[ctcm_pkg::TMO_LSB +: 2];
    // Same polarity bit serves interrupt and forcing
    assign sense_active = (emergency_sense_input_i == reg_pol);
    assign step_bus.mode = ctcm_pkg::ctcm_mode_t'(cpu_mode_i);
    assign step_bus.efficiency = cpu_efficiency;

    // Sample rate halves per holdoff code step
    assign base_tick = (div_cnt == 16'(SAMPLE_DIV - 1));
    assign sample_tick = base_tick &&
        (sub_cnt == 4'((4'd1 << cooldown_holdoff) - 4'd1));
    assign holdoff_end = sample_tick && (sample_cnt == 32'(SAMPLES_PER_HOLDOFF - 1));

    always_comb
    begin
        unique case (cooldown_timeout)
            2'b00: timeout_periods = ctcm_pkg::TMO_00_PERIODS;
            2'b01: timeout_periods = 3'd3;
            2'b10: timeout_periods = 3'd4;
            2'b11: timeout_periods = 3'd5;
        endcase
    end
    assign last_period = (period_cnt == timeout_periods - 3'd1);

    // Registers
    assign wr_lockable = reg_wr_i && !locked;
    always_comb
    begin
        next_eql = reg_eql;
        next_otl = reg_otl;
        next_cfg = reg_cfg;
        next_stp_c = reg_stp_c;
        next_stp = reg_stp;
        next_evt_en = reg_evt_en;
        next_pol = reg_pol;
        next_rdata = 8'h00;
        if (wr_lockable)
        begin
            unique case (reg_addr_i)
                ctcm_pkg::ADDR_ENABLE_EQL: next_eql = reg_wdata_i;
                ctcm_pkg::ADDR_OTL: next_otl = reg_wdata_i;
                ctcm_pkg::ADDR_COOL_CFG: next_cfg = reg_wdata_i;
                ctcm_pkg::ADDR_STPCFG_A: next_stp[0] = reg_wdata_i[ctcm_pkg::STP_A_BIT];
                ctcm_pkg::ADDR_STPCFG_B: next_stp[1] = reg_wdata_i[ctcm_pkg::STP_B_BIT];
                ctcm_pkg::ADDR_STPCFG_C: next_stp_c = reg_wdata_i;
                default: ;
            endcase
        end
        if (reg_wr_i)
        begin
            // Event enable and polarity stay writable
            if (reg_addr_i == ctcm_pkg::ADDR_EVENT_EN)
                next_evt_en = reg_wdata_i[ctcm_pkg::EVENT_EN_BIT];
            if (reg_addr_i == ctcm_pkg::ADDR_SENSE_POL)
                next_pol = reg_wdata_i[ctcm_pkg::SENSE_POL_BIT];
        end
        if (reg_rd_i)
        begin
            unique case (reg_addr_i)
                ctcm_pkg::ADDR_ENABLE_EQL:
                    next_rdata = {(state != ctcm_pkg::CTCM_MONITOR),
                        reg_eql[ctcm_pkg::EQL_MSB:0]};
                ctcm_pkg::ADDR_OTL: next_rdata = reg_otl;
                ctcm_pkg::ADDR_COOL_CFG: next_rdata = reg_cfg;
                ctcm_pkg::ADDR_STPCFG_A: next_rdata = 8'(reg_stp[0]) << ctcm_pkg::STP_A_BIT;
                ctcm_pkg::ADDR_STPCFG_B: next_rdata = 8'(reg_stp[1]) << ctcm_pkg::STP_B_BIT;
                ctcm_pkg::ADDR_STPCFG_C: next_rdata = reg_stp_c;
                ctcm_pkg::ADDR_EVENT_EN: next_rdata = 8'(reg_evt_en) << ctcm_pkg::EVENT_EN_BIT;
                ctcm_pkg::ADDR_SENSE_POL: next_rdata = 8'(reg_pol) << ctcm_pkg::SENSE_POL_BIT;
                ctcm_pkg::ADDR_STATUS: next_rdata = activity_counter[23:16];
                default: next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            reg_eql <= ctcm_pkg::RESET_REG;
            reg_otl <= ctcm_pkg::RESET_REG;
            reg_cfg <= ctcm_pkg::RESET_REG;
            reg_stp_c <= ctcm_pkg::RESET_REG;
            reg_stp <= 2'b00;
            reg_evt_en <= 1'b0;
            reg_pol <= 1'b0;
            rdata <= 8'h00;
        end
        else
        begin
            reg_eql <= next_eql;
            reg_otl <= next_otl;
            reg_cfg <= next_cfg;
            reg_stp_c <= next_stp_c;
            reg_stp <= next_stp;
            reg_evt_en <= next_evt_en;
            reg_pol <= next_pol;
            rdata <= next_rdata;
        end
    end

    // Activity monitor and cool-down sequencing
    always_comb
    begin
        logic [7:0] upper;
        logic [ctcm_pkg::CNT_W-1:0] stepped;
        upper = activity_counter[23:16];
        stepped = activity_counter + ctcm_pkg::CNT_W'(signed'(step_bus.step));
        next_state = state;
        next_activity_counter = activity_counter;
        next_div_cnt = base_tick ? 16'h0000 : div_cnt + 16'h0001;
        next_sub_cnt = base_tick ? ((sample_tick) ? 4'h0 : sub_cnt + 4'h1) : sub_cnt;
        next_sample_cnt = holdoff_end ? 32'h0 : (sample_tick ? sample_cnt + 32'h1 : sample_cnt);
        next_period_cnt = period_cnt;
        next_irq = 1'b0;
        unique case (state)
            ctcm_pkg::CTCM_MONITOR:
            begin
                if (sense_active)
                begin
                    next_state = ctcm_pkg::CTCM_COOL_EMERG;
                    next_irq = reg_evt_en;
                end
                else if (locked && sample_tick)
                begin
                    next_activity_counter = stepped;
                    if (holdoff_end)
                    begin
                        upper = stepped[23:16];
                        if (upper >= overtemp_limit)
                        begin
                            next_state = ctcm_pkg::CTCM_COOL_ACT;
                            next_period_cnt = 3'd0;
                            next_irq = reg_evt_en;
                        end
                        else if (upper > equilibrium_level)
                            next_activity_counter = {upper - equilibrium_level, stepped[15:0]};
                        else
                            next_activity_counter = '0;
                    end
                end
            end
            ctcm_pkg::CTCM_COOL_ACT:
            begin
                // Counter frozen while cooling
                if (holdoff_end)
                begin
                    if (last_period)
                    begin
                        // Sense still active keeps the CPU slowed, no exit event
                        if (sense_active)
                            next_state = ctcm_pkg::CTCM_COOL_EMERG;
                        else
                        begin
                            next_state = ctcm_pkg::CTCM_MONITOR;
                            next_irq = reg_evt_en;
                        end
                        next_activity_counter = '0;
                        next_sample_cnt = 32'h0;
                    end
                    else
                        next_period_cnt = period_cnt + 3'd1;
                end
            end
            ctcm_pkg::CTCM_COOL_EMERG:
            begin
                if (!sense_active)
                begin
                    next_state = ctcm_pkg::CTCM_MONITOR;
                    next_activity_counter = '0;
                    next_sample_cnt = 32'h0;
                    next_irq = reg_evt_en;
                end
            end
        endcase
    end

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state <= ctcm_pkg::CTCM_MONITOR;
            activity_counter <= '0;
            div_cnt <= 16'h0000;
            sub_cnt <= 4'h0;
            sample_cnt <= 32'h0;
            period_cnt <= 3'd0;
            irq <= 1'b0;
        end
        else
        begin
            state <= next_state;
            activity_counter <= next_activity_counter;
            div_cnt <= next_div_cnt;
            sub_cnt <= next_sub_cnt;
            sample_cnt <= next_sample_cnt;
            period_cnt <= next_period_cnt;
            irq <= next_irq;
        end
    end

    assign reg_rdata_o = rdata;
    assign cooldown_active_o = (state != ctcm_pkg::CTCM_MONITOR);
    assign cooldown_clock_divisor_o = reg_cfg[ctcm_pkg::DIV_LSB +: 2];
    assign system_management_interrupt_o = irq;
    assign stop_clock_cfg_c_o = reg_stp_c;
    assign stop_clock_cfg_o = reg_stp;
endmodule

// ### shared/ctcm_pkg.sv
// Purpose: Constants and types for the CPU thermal cool-down manager
// Assumes: 250 MHz clock, 8-bit register port
// Notes: Behaviour list below
// Behaviour
// - Once enabled, thermal and stop-clock configuration writes are ignored until reset.
// - Enable bit reads 1 only while cool-down clocking is in effect.
// - Above equilibrium subtract it from upper byte; otherwise clear the counter.
// - Full-speed sample adds 2 plus the CPU efficiency setting.
// - Holdoff code selects 32, 64, 128 or 256 second comparison period.
// - With 64 s holdoff the CPU mode is sampled 16384 times per second.
// - Cool-down rate code selects CPU clock divide by 2, 3, 4 or 8.
// - Cool-down timeout is 3, 4 or 5 holdoff periods for codes 01 to 11.
// - At timeout clear the counter, restore normal clocking, restart monitoring.
// - With its enable set, cool-down entry and exit raise a management interrupt.
// - Active emergency sense input holds cool-down until it deactivates.
// - One polarity bit sets the emergency sense active level for both uses.
// - Emergency forcing works with the activity unit disabled.
// - Emergency sense interrupt enables operate independently of overtemp enable.
// - Emergency sense works when delivered through an external multiplexer.
// - Mode steps: full +2, div2/3 +1, div4 0, div8 -1, slower or stopped -2.
// - Efficiency is added only for samples with a positive mode step.
// - Activity counter is 24 bits; comparisons use its upper byte.
// - No sampling or counting while cool-down clocking is engaged.
package ctcm_pkg;
    localparam int CLK_HZ = 250_000_000;
    localparam int BASE_SAMPLE_HZ = 32768;
    // Cycles per base sample tick, rounded down
    localparam int SAMPLE_DIV = CLK_HZ / BASE_SAMPLE_HZ;
    localparam int BASE_HOLDOFF_S = 32;
    // Samples per holdoff period, same at every rate
    localparam int SAMPLES_PER_HOLDOFF = BASE_SAMPLE_HZ * BASE_HOLDOFF_S;
    localparam logic [7:0] ADDR_ENABLE_EQL = 8'ha5;
    localparam logic [7:0] ADDR_OTL = 8'ha6;
    localparam logic [7:0] ADDR_COOL_CFG = 8'ha7;
    localparam logic [7:0] ADDR_STPCFG_A = 8'h61;
    localparam logic [7:0] ADDR_STPCFG_B = 8'h66;
    localparam logic [7:0] ADDR_STPCFG_C = 8'hb0;
    localparam logic [7:0] ADDR_EVENT_EN = 8'hdb;
    localparam logic [7:0] ADDR_SENSE_POL = 8'h40;
    localparam logic [7:0] ADDR_STATUS = 8'hc0;
    localparam int ENABLE_BIT = 7;
    localparam int EQL_MSB = 6;
    localparam int EFF_LSB = 6;
    localparam int HOLD_LSB = 4;
    localparam int DIV_LSB = 2;
    localparam int TMO_LSB = 0;
    localparam int STP_A_BIT = 2;
    localparam int STP_B_BIT = 0;
    localparam int EVENT_EN_BIT = 6;
    localparam int SENSE_POL_BIT = 2;
    localparam logic [7:0] RESET_REG = 8'h00;
    localparam int CNT_W = 24;
    localparam logic [2:0] TMO_00_PERIODS = 3'd2;
    typedef enum logic [2:0]
    {
        CTCM_FULL,
        CTCM_DIV2,
        CTCM_DIV3,
        CTCM_DIV4,
        CTCM_DIV8,
        CTCM_DIV16,
        CTCM_STOP
    } ctcm_mode_t;
    typedef enum logic [1:0]
    {
        CTCM_MONITOR,
        CTCM_COOL_ACT,
        CTCM_COOL_EMERG
    } ctcm_state_t;
endpackage

// ### shared/ctcm_step_if.sv
// Purpose: Carries a CPU mode and efficiency to the step unit and its result back
// Assumes: Combinational path
// Notes: Used only inside the manager
`timescale 1ns/1ps
interface ctcm_step_if;
    ctcm_pkg::ctcm_mode_t mode;
    logic [1:0] efficiency;
    logic signed [3:0] step;
    modport user (output mode, output efficiency, input step);
    modport calc (input mode, input efficiency, output step);
endinterface

// ### core/ctcm_step.sv
// Purpose: Signed activity increment for one sample
// Assumes: Mode encodings from the package
// Notes: Purely combinational
`timescale 1ns/1ps
module ctcm_step
(
    // Step request and result
    ctcm_step_if.calc s
);
    logic signed [3:0] base;
    always_comb
    begin
        unique case (s.mode)
            ctcm_pkg::CTCM_FULL: base = 4'sd2;
            ctcm_pkg::CTCM_DIV2, ctcm_pkg::CTCM_DIV3: base = 4'sd1;
            ctcm_pkg::CTCM_DIV4: base = 4'sd0;
            ctcm_pkg::CTCM_DIV8: base = -4'sd1;
            default: base = -4'sd2;
        endcase
        // Efficiency only on positive steps
        if (base > 4'sd0)
            s.step = base + $signed({2'b00, s.efficiency});
        else
            s.step = base;
    end
endmodule

// ### testbench/ctcm_sensor_model.sv
// Purpose: External thermal sensor driving the emergency sense pin
// Assumes: Pin changes just after a rising edge
// Notes: Inactive level whenever not hot
`timescale 1ns/1ps
module ctcm_sensor_model
(
    // Clock and sensor state
    input wire logic mclk_i,
    input wire logic hot_i,
    input wire logic pol_i,
    // Sense pin
    output logic sense_o
);
    initial sense_o = 1'b1;
    always @(posedge mclk_i)
    begin
        sense_o <= hot_i ? pol_i : ~pol_i;
    end
endmodule

// ### testbench/ctcm_top_chk.sv
// Purpose: Port assertions for the thermal cool-down manager
// Assumes: Sees only the top module ports
// Notes: Tracks polarity, lock, event enable and divisor writes
`timescale 1ns/1ps
module ctcm_top_chk
#(
    parameter int SAMPLE_DIV = ctcm_pkg::SAMPLE_DIV,
    parameter int SAMPLES_PER_HOLDOFF = ctcm_pkg::SAMPLES_PER_HOLDOFF
)
(
    // Clock, reset and register port
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    // Status, sense and control
    input wire logic [2:0] cpu_mode_i,
    input wire logic emergency_sense_input_i,
    input wire logic cooldown_active_o,
    input wire logic [1:0] cooldown_clock_divisor_o,
    input wire logic system_management_interrupt_o,
    input wire logic [7:0] stop_clock_cfg_c_o,
    input wire logic [1:0] stop_clock_cfg_o
);
    logic pol, next_pol, lock, next_lock, irq_en, next_irq_en;
    logic [1:0] div, next_div;
    logic sense_act, rd_stat;
    assign sense_act = (emergency_sense_input_i == pol);
    assign rd_stat = reg_rd_i && (reg_addr_i == ctcm_pkg::ADDR_ENABLE_EQL);
    always_comb
    begin
        next_pol = pol;
        next_lock = lock;
        next_div = div;
        next_irq_en = irq_en;
        if (reg_wr_i && reg_addr_i == ctcm_pkg::ADDR_SENSE_POL)
            next_pol = reg_wdata_i[ctcm_pkg::SENSE_POL_BIT];
        if (reg_wr_i && reg_addr_i == ctcm_pkg::ADDR_EVENT_EN)
            next_irq_en = reg_wdata_i[ctcm_pkg::EVENT_EN_BIT];
        if (reg_wr_i && !lock && reg_addr_i == ctcm_pkg::ADDR_COOL_CFG)
            next_div = reg_wdata_i[3:2];
        if (reg_wr_i && reg_addr_i == ctcm_pkg::ADDR_ENABLE_EQL && reg_wdata_i[7])
            next_lock = 1'b1;
    end
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            pol <= 1'b0;
            lock <= 1'b0;
            div <= 2'h0;
            irq_en <= 1'b0;
        end
        else
        begin
            pol <= next_pol;
            lock <= next_lock;
            div <= next_div;
            irq_en <= next_irq_en;
        end
    end
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_n_i);
    a_status_bit: assert property (
        $past(rd_stat) |-> reg_rdata_o[7] == $past(cooldown_active_o))
        else $error("status bit differs from cool-down state");
    a_div_follow: assert property (
        !$past(reg_wr_i) && !$past(reg_wr_i, 2) |-> cooldown_clock_divisor_o == div)
        else $error("divisor output differs from setting");
    a_irq_raise: assert property (
        irq_en && $changed(cooldown_active_o) |-> ##[0:1] system_management_interrupt_o)
        else $error("no interrupt on cool-down change");
    a_irq_cause: assert property (
        system_management_interrupt_o |-> cooldown_active_o != $past(cooldown_active_o)
        || $past(cooldown_active_o) != $past(cooldown_active_o, 2))
        else $error("interrupt without cool-down change");
    a_irq_single: assert property (
        system_management_interrupt_o |=> !system_management_interrupt_o)
        else $error("interrupt longer than one cycle");
    a_emerg_engage: assert property (
        sense_act |=> cooldown_active_o)
        else $error("active sense did not force cool-down");
    a_emerg_leave: assert property (
        !lock && !sense_act |=> !cooldown_active_o)
        else $error("cool-down held after sense released");
    a_stop_lock: assert property (
        lock && $past(lock) |-> $stable(stop_clock_cfg_o) && $stable(stop_clock_cfg_c_o))
        else $error("stop-clock setting changed after lock");
endmodule
bind ctcm_top ctcm_top_chk #(.SAMPLE_DIV(SAMPLE_DIV), .SAMPLES_PER_HOLDOFF(SAMPLES_PER_HOLDOFF))
    ctcm_top_chk_inst (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .cpu_mode_i(cpu_mode_i),
    .emergency_sense_input_i(emergency_sense_input_i), .cooldown_active_o(cooldown_active_o),
    .cooldown_clock_divisor_o(cooldown_clock_divisor_o),
    .system_management_interrupt_o(system_management_interrupt_o),
    .stop_clock_cfg_c_o(stop_clock_cfg_c_o), .stop_clock_cfg_o(stop_clock_cfg_o));

// ### testbench/ctcm_top_tb.sv
// Purpose: Self-checking bench for the thermal cool-down manager
// Assumes: Shortened sample and holdoff counts
// Notes: Register model kept in an array
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_count++; \
    $display("wrong value at %0t: got %h exp %h", $time, g, e); end end
module ctcm_top_tb;
    logic mclk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00;
    logic [7:0] reg_wdata_i = 8'h00;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [2:0] cpu_mode_i = 3'h0;
    logic hot = 1'b0;
    logic pol = 1'b0;
    logic emergency_sense_input_i, cooldown_active_o, system_management_interrupt_o;
    logic [7:0] reg_rdata_o, stop_clock_cfg_c_o;
    logic [1:0] cooldown_clock_divisor_o, stop_clock_cfg_o;
    int err_count = 0;
    int checked = 0;
    int smi_cnt = 0;
    logic [7:0] mreg [256];
    logic locked, cool_exp;
    ctcm_top #(.SAMPLE_DIV(4), .SAMPLES_PER_HOLDOFF(8)) ctcm_top_inst (.mclk_i(mclk_i),
        .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .cpu_mode_i(cpu_mode_i), .emergency_sense_input_i(emergency_sense_input_i),
        .cooldown_active_o(cooldown_active_o), .cooldown_clock_divisor_o(cooldown_clock_divisor_o),
        .system_management_interrupt_o(system_management_interrupt_o),
        .stop_clock_cfg_c_o(stop_clock_cfg_c_o), .stop_clock_cfg_o(stop_clock_cfg_o));
    ctcm_sensor_model ctcm_sensor_model_inst (.mclk_i(mclk_i), .hot_i(hot), .pol_i(pol),
        .sense_o(emergency_sense_input_i));
    always #2 mclk_i = ~mclk_i;
    always @(posedge mclk_i) cpu_mode_i <= 3'($urandom % 8);
    always @(negedge mclk_i) if (system_management_interrupt_o === 1'b1) smi_cnt++;
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge mclk_i);
        reg_wr_i <= 1'b0;
        if (!(locked && a inside {8'ha5, 8'ha6, 8'ha7, 8'h61, 8'h66, 8'hb0})) mreg[a] = d;
        if (a == ctcm_pkg::ADDR_ENABLE_EQL && d[7]) locked = 1'b1;
    endtask
    task automatic rd(input logic [7:0] a);
        logic [7:0] e;
        e = (a inside {8'ha6, 8'ha7}) ? mreg[a] : 8'h00;
        if (a == 8'ha5) e = {cool_exp, mreg[a][6:0]};
        @(posedge mclk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge mclk_i);
        reg_rd_i <= 1'b0;
        #1;
        `CHK(reg_rdata_o, e)
    endtask
    task automatic wait_cool(input logic v, input int lim);
        int i;
        i = 0;
        while (cooldown_active_o !== v && i < lim)
        begin
            @(posedge mclk_i);
            #1;
            i++;
        end
        `CHK(cooldown_active_o, v)
    endtask
    task automatic reset_dut();
        rst_n_i <= 1'b0;
        hot <= 1'b0;
        pol <= 1'b0;
        repeat (3) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        foreach (mreg[i]) mreg[i] = 8'h00;
        locked = 1'b0;
        cool_exp = 1'b0;
    endtask
    task automatic end_of_test();
        $display("mismatches %0d comparisons %0d", err_count, checked);
        if (err_count == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial
    begin
        #(4 * 50000);
        err_count++;
        end_of_test();
    end
    initial
    begin
        int n, t, expn, tol;
        logic [7:0] cfg, sc;
        logic p;
        void'($urandom(68));
        reset_dut();
        rd(8'ha5);
        rd(8'ha6);
        rd(8'ha7);
        rd(8'h13);
        sc = 8'($urandom);
        wr(8'h61, 8'h04);
        wr(8'h66, 8'h01);
        wr(8'hb0, sc);
        @(posedge mclk_i);
        #1;
        `CHK(stop_clock_cfg_o, 2'b11)
        `CHK(stop_clock_cfg_c_o, sc)
        p = 1'($urandom);
        wr(8'h40, {5'h0, p, 2'h0});
        pol <= p;
        wr(8'hdb, 8'h40);
        repeat (3) @(posedge mclk_i);
        smi_cnt = 0;
        hot <= 1'b1;
        wait_cool(1'b1, 8);
        cool_exp = 1'b1;
        rd(8'ha5);
        `CHK(emergency_sense_input_i, p)
        rd(8'hc0);
        `CHK(cooldown_clock_divisor_o, 2'b00)
        repeat (40) @(posedge mclk_i);
        #1;
        `CHK(cooldown_active_o, 1'b1)
        hot <= 1'b0;
        wait_cool(1'b0, 8);
        cool_exp = 1'b0;
        repeat (3) @(posedge mclk_i);
        `CHK(smi_cnt, 2)
        for (t = 0; t < 4; t++)
        begin
            reset_dut();
            cfg = {2'($urandom), 2'(t), 2'($urandom), 2'(t)};
            wr(8'ha7, cfg);
            wr(8'hdb, 8'h40);
            wr(8'h61, 8'h04);
            wr(8'ha5, 8'h80 | 8'($urandom % 128));
            wr(8'ha6, 8'($urandom) | 8'h01);
            wr(8'ha7, ~cfg);
            wr(8'h61, 8'h00);
            rd(8'ha6);
            rd(8'ha7);
            `CHK(stop_clock_cfg_o[0], 1'b1)
            smi_cnt = 0;
            wait_cool(1'b1, 1200);
            `CHK(cooldown_clock_divisor_o, cfg[3:2])
            n = 0;
            while (cooldown_active_o === 1'b1 && n < 4000)
            begin
                @(posedge mclk_i);
                #1;
                n++;
            end
            expn = ((t == 0) ? 2 : t + 2) * (32 << t);
            tol = (4 << t) + 2;
            `CHK(n >= expn - tol && n <= expn + tol, 1'b1)
            repeat (2) @(posedge mclk_i);
            `CHK(smi_cnt, 2)
            rd(8'ha5);
        end
        end_of_test();
    end
endmodule
